/* File: design/hsc_pkg.sv */
// Shared constants and types for the per-channel statistics counter bank
package hsc_pkg;
	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int CNT_W = 24;
	localparam int CH_W = 5;
	localparam int LEN_W = 14;
	localparam int NUM_LIMITS = 3;
	localparam int NUM_CNT = 10;
	localparam int MIN_MSG_BYTES = 3;

	// ----------------------------------------------------------------
	// Counter slots; rx order is the shared-memory word order
	// ----------------------------------------------------------------
	localparam int RX_OCT = 0;
	localparam int RX_MSG = 1;
	localparam int RX_ALN = 2;
	localparam int RX_FCS = 3;
	localparam int RX_ABT = 4;
	localparam int RX_LONG = 5;
	localparam int RX_SHORT = 6;
	localparam int TX_MSG = 7;
	localparam int TX_OCT = 8;
	localparam int TX_ABT = 9;
	localparam int RX_WORDS = 8;
	localparam int TX_WORDS = 4;

	// ----------------------------------------------------------------
	// Values
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] CNT_MAX = 24'hffffff;
	localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
	localparam logic [21:0] CNT_BASE_ADDR = 22'h008000;
	localparam logic [14:0] LEN_ZERO_WORDS = 15'h4000;
	localparam logic [4:0] CONFIG_RD_DEFAULT = 5'h01;

	typedef logic [NUM_LIMITS-1:0][LEN_W-1:0] hsc_limits_t;

	// End-of-message report from the receive serial side
	typedef struct packed {
		logic [CH_W-1:0] chan;
		logic [LEN_W-1:0] len;
		logic [1:0] lim_sel;
		logic abort;
		logic align_err;
		logic fcs_err;
		logic local_discard;
		logic data_reached;
	} hsc_rx_end_t;

	// Configuration-read service request
	typedef struct packed {
		logic [4:0] opcode;
		logic completion_irq_enable;
		logic [LEN_W-1:0] length;
		logic [29:0] smem_ptr;
		logic [21:0] base;
		logic is_tx;
	} hsc_req_t;

	// One word written to shared memory
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
	} hsc_wr_t;
endpackage : hsc_pkg

/* File: design/hsc_rx_classify.sv */
// Sorts one finished receive message into at most one counter slot; a local discard with data reached gets none
module hsc_rx_classify (
	input hsc_pkg::hsc_rx_end_t msg,
	input hsc_pkg::hsc_limits_t limits,
	output logic [hsc_pkg::RX_SHORT:0] hit
);
	import hsc_pkg::*;

	logic too_long;
	logic any_err;

	always_comb begin
		too_long = 1'b0;
		if (msg.lim_sel < 2'(NUM_LIMITS)) begin
			too_long = msg.len > limits[msg.lim_sel];
		end
		any_err = msg.abort | too_long | msg.align_err | msg.fcs_err | msg.local_discard;
		hit = '0;
		if (!msg.data_reached && any_err) begin
			hit[RX_SHORT] = 1'b1;
		end else if (msg.local_discard) begin
			hit = '0;
		end else if (msg.abort) begin
			hit[RX_ABT] = 1'b1;
		end else if (too_long) begin
			hit[RX_LONG] = 1'b1;
		end else if (msg.align_err) begin
			hit[RX_ALN] = 1'b1;
		end else if (msg.fcs_err) begin
			hit[RX_FCS] = 1'b1;
		end else if (msg.len < LEN_W'(MIN_MSG_BYTES)) begin
			hit[RX_SHORT] = 1'b1;
		end else begin
			hit[RX_MSG] = 1'b1;
		end
	end
endmodule : hsc_rx_classify

/* File: design/hsc_chan_bank.sv */
// Active and held counter sets of one channel
module hsc_chan_bank (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic latch,
	input wire logic clr,
	input wire logic [hsc_pkg::NUM_CNT-1:0] inc,
	output logic [hsc_pkg::NUM_CNT-1:0][hsc_pkg::CNT_W-1:0] held
);
	import hsc_pkg::*;

	logic [NUM_CNT-1:0][CNT_W-1:0] act_q;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	for (genvar k = 0; k < NUM_CNT; k++) begin : g_cnt
		// Latching restarts the period from the event of this very cycle
		always_ff @(posedge clk) begin
			if (srst) begin
				act_q[k] <= CNT_RST;
			end else if (ce) begin
				if (clr) begin
					act_q[k] <= CNT_RST;
				end else if (latch) begin
					act_q[k] <= {{(CNT_W-1){1'b0}}, inc[k]};
				end else if (inc[k] && act_q[k] != CNT_MAX) begin
					act_q[k] <= act_q[k] + 24'h000001;
				end
			end
		end

		always_ff @(posedge clk) begin
			if (srst) begin
				held[k] <= CNT_RST;
			end else if (ce) begin
				if (clr) begin
					held[k] <= CNT_RST;
				end else if (latch) begin
					held[k] <= act_q[k];
				end
			end
		end

		a_sat_hold: assert property (ce && act_q[k] == CNT_MAX && !clr && !latch |=> act_q[k] == CNT_MAX)
			else $error("saturated counter moved");
		a_latch_copy: assert property (ce && latch && !clr |=> held[k] == $past(act_q[k]))
			else $error("held value is not the active value at the pulse");
		a_latch_restart: assert property (ce && latch && !clr |=> act_q[k] == CNT_W'($past(inc[k])))
			else $error("event at latch lost or doubled");
		a_clear_zero: assert property (ce && clr |=> act_q[k] == CNT_RST && held[k] == CNT_RST)
			else $error("channel clear left a nonzero counter");
	end
endmodule : hsc_chan_bank

/* File: design/hsc_stat_counters.sv */
// Per-channel HDLC statistics counters with period latching and config-read engine
module hsc_stat_counters #(
	parameter int N_CH = 32,
	parameter logic [4:0] CONFIG_RD = hsc_pkg::CONFIG_RD_DEFAULT
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic one_sec_pin,
	input wire logic chan_evt_v,
	input wire logic [hsc_pkg::CH_W-1:0] chan_evt_id,
	input wire logic rx_octet_v,
	input wire logic [hsc_pkg::CH_W-1:0] rx_octet_chan,
	input wire logic rx_end_v,
	input hsc_pkg::hsc_rx_end_t rx_end,
	input hsc_pkg::hsc_limits_t max_len_limits,
	input wire logic tx_octet_v,
	input wire logic [hsc_pkg::CH_W-1:0] tx_octet_chan,
	input wire logic tx_end_v,
	input wire logic [hsc_pkg::CH_W-1:0] tx_end_chan,
	input wire logic tx_end_aborted,
	input wire logic req_v,
	input hsc_pkg::hsc_req_t req,
	output logic req_ready,
	output logic wr_v,
	output hsc_pkg::hsc_wr_t wr,
	input wire logic wr_ready,
	output logic command_done_ack,
	output logic completion_irq
);
	import hsc_pkg::*;

	if (N_CH < 1 || N_CH > (1 << CH_W)) begin : g_bad_n_ch
		$error("N_CH must lie between 1 and 2**CH_W");
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	// ----------------------------------------------------------------
	// One-second pin synchroniser and edge detect
	// ----------------------------------------------------------------
	logic sec_meta_q;
	logic sec_sync_q;
	logic sec_prev_q;
	logic latch;

	always_ff @(posedge clk) begin
		if (srst) begin
			sec_meta_q <= 1'b0;
			sec_sync_q <= 1'b0;
			sec_prev_q <= 1'b0;
		end else if (ce) begin
			sec_meta_q <= one_sec_pin;
			sec_sync_q <= sec_meta_q;
			sec_prev_q <= sec_sync_q;
		end
	end

	// Edge-triggered, so each pulse sampled high on at least one ce edge latches once, however wide
	assign latch = sec_sync_q & ~sec_prev_q;

	// ----------------------------------------------------------------
	// Event steering into the channel banks
	// ----------------------------------------------------------------
	logic [RX_SHORT:0] rx_hit;
	logic [N_CH-1:0][NUM_CNT-1:0] inc;
	logic [N_CH-1:0][NUM_CNT-1:0][CNT_W-1:0] held;

	hsc_rx_classify u_classify (
		.msg(rx_end),
		.limits(max_len_limits),
		.hit(rx_hit)
	);

	for (genvar c = 0; c < N_CH; c++) begin : g_ch
		logic rx_end_here;
		logic tx_end_here;

		assign rx_end_here = rx_end_v && rx_end.chan == CH_W'(c);
		assign tx_end_here = tx_end_v && tx_end_chan == CH_W'(c);
		assign inc[c][RX_OCT] = rx_octet_v && rx_octet_chan == CH_W'(c);
		assign inc[c][RX_SHORT:RX_MSG] = rx_end_here ? rx_hit[RX_SHORT:RX_MSG] : '0;
		assign inc[c][TX_OCT] = tx_octet_v && tx_octet_chan == CH_W'(c);
		assign inc[c][TX_MSG] = tx_end_here;
		assign inc[c][TX_ABT] = tx_end_here && tx_end_aborted;

		hsc_chan_bank u_bank (
			.clk(clk),
			.srst(srst),
			.ce(ce),
			.latch(latch),
			.clr(chan_evt_v && chan_evt_id == CH_W'(c)),
			.inc(inc[c]),
			.held(held[c])
		);
	end

	// ----------------------------------------------------------------
	// Held-set read decode
	// ----------------------------------------------------------------
	logic [21:0] base_q;
	logic is_tx_q;
	logic [21:0] rd_off;
	logic [CH_W-1:0] rd_ch;
	logic [3:0] rd_idx;
	logic rd_hit;
	logic [31:0] rd_word;

	// Only the held set is reachable here; the active set has no address
	always_comb begin
		rd_off = base_q - CNT_BASE_ADDR;
		rd_ch = '0;
		rd_idx = '0;
		rd_hit = 1'b0;
		if (is_tx_q) begin
			rd_ch = rd_off[CH_W+1:2];
			rd_idx = 4'(TX_MSG) + {2'b00, rd_off[1:0]};
			rd_hit = base_q >= CNT_BASE_ADDR && rd_off < 22'(N_CH * TX_WORDS)
				&& rd_off[1:0] != 2'(TX_WORDS - 1);
		end else begin
			rd_ch = rd_off[CH_W+2:3];
			rd_idx = {1'b0, rd_off[2:0]};
			rd_hit = base_q >= CNT_BASE_ADDR && rd_off < 22'(N_CH * RX_WORDS)
				&& rd_off[2:0] != 3'(RX_WORDS - 1);
		end
		rd_word = '0;
		if (rd_hit) begin
			rd_word = {8'h00, held[rd_ch][rd_idx]};
		end
	end

	// ----------------------------------------------------------------
	// Config-read engine
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOAD = 2'b01,
		ST_SEND = 2'b10,
		ST_DONE = 2'b11
	} hsc_state_t;

	hsc_state_t state_q;
	logic [14:0] rem_q;
	logic [29:0] ptr_q;
	logic irq_en_q;
	logic req_take;

	assign req_ready = state_q == ST_IDLE;
	assign req_take = ce && req_v && req_ready;

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= ST_IDLE;
		end else if (ce) begin
			unique case (state_q)
				ST_IDLE: begin
					if (req_v) begin
						state_q <= (req.opcode == CONFIG_RD) ? ST_LOAD : ST_DONE;
					end
				end
				ST_LOAD: begin
					state_q <= ST_SEND;
				end
				ST_SEND: begin
					if (wr_ready) begin
						state_q <= (rem_q == 15'h0001) ? ST_DONE : ST_LOAD;
					end
				end
				ST_DONE: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Request fields and walking addresses
	always_ff @(posedge clk) begin
		if (srst) begin
			rem_q <= '0;
			ptr_q <= '0;
			base_q <= '0;
			is_tx_q <= 1'b0;
			irq_en_q <= 1'b0;
		end else if (ce) begin
			if (req_take) begin
				rem_q <= (req.length == '0) ? LEN_ZERO_WORDS : {1'b0, req.length};
				ptr_q <= req.smem_ptr;
				base_q <= req.base;
				is_tx_q <= req.is_tx;
				irq_en_q <= req.completion_irq_enable & (req.opcode == CONFIG_RD);
			end else if (state_q == ST_SEND && wr_ready) begin
				rem_q <= rem_q - 15'h0001;
				ptr_q <= ptr_q + 30'h00000001;
				base_q <= base_q + 22'h000001;
			end
		end
	end

	// Registered write word; data may reflect a latch taken mid-transfer
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_v <= 1'b0;
			wr <= '0;
		end else if (ce) begin
			if (state_q == ST_LOAD) begin
				wr_v <= 1'b1;
				wr.addr <= {ptr_q, 2'b00};
				wr.data <= rd_word;
			end else if (state_q == ST_SEND && wr_ready) begin
				wr_v <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			command_done_ack <= 1'b0;
			completion_irq <= 1'b0;
		end else if (ce) begin
			command_done_ack <= state_q == ST_DONE;
			completion_irq <= state_q == ST_DONE && irq_en_q;
		end else begin
			command_done_ack <= 1'b0;
			completion_irq <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_latch_edge: assert property (ce && $past(ce) && sec_sync_q && !sec_prev_q |-> latch)
		else $error("synchronised rising edge did not latch");
	a_one_class: assert property (rx_end_v |-> $onehot0(rx_hit))
		else $error("message credited to more than one counter");
	a_abort_first: assert property (rx_end_v && rx_end.abort && rx_end.data_reached && !rx_end.local_discard
		|-> rx_hit[RX_ABT])
		else $error("aborted message not counted as abort");
	a_discard_none: assert property (rx_end_v && rx_end.local_discard && rx_end.data_reached
		|-> rx_hit == '0)
		else $error("local discard counted");
	a_len_zero_full: assert property (req_take && req.opcode == CONFIG_RD && req.length == '0
		|=> rem_q == LEN_ZERO_WORDS)
		else $error("zero length not 16384 words");
	a_ptr_align: assert property (wr_v |-> wr.addr[1:0] == 2'b00 && wr.data[31:24] == 8'h00)
		else $error("unaligned address or reserved bits set");
	a_word_count: assert property (req_take && req.opcode == CONFIG_RD && req.length == 14'h0001
		##1 ce ##1 ce && wr_ready ##1 ce |=> command_done_ack)
		else $error("one-word transfer did not finish in time");
	a_irq_with_done: assert property (completion_irq |-> command_done_ack)
		else $error("interrupt without completion");

	c_latch: cover property (latch);
	c_irq_done: cover property (completion_irq);
	c_zero_len: cover property (req_take && req.length == '0);
	c_latch_event: cover property (latch && |inc);
endmodule : hsc_stat_counters

/* File: dv/hsc_host_mem.sv */
// Shared-memory sink standing in for the host side of counter reads
module hsc_host_mem (
	input wire logic clk,
	input wire logic slow,
	input wire logic wr_v,
	input hsc_pkg::hsc_wr_t wr,
	output logic wr_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	import hsc_pkg::*;
	logic [31:0] mem [0:63];
	int n_wr = 0;
	logic [31:0] last_addr = 32'h0;
	logic tgl = 1'b0;
	// ----------------------------------------------------------------
	// Acceptance
	// ----------------------------------------------------------------
	// A slow host takes a word only every other cycle, so the device must hold it
	always @(posedge clk) begin
		tgl <= ~tgl;
	end
	assign wr_ready = slow ? tgl : 1'b1;
	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (wr_v && wr_ready) begin
			mem[wr.addr[7:2]] <= wr.data;
			last_addr <= wr.addr;
			n_wr <= n_wr + 1;
		end
	end
endmodule : hsc_host_mem

/* File: dv/hsc_stat_counters_tb_top.sv */
// Self-checking bench for the statistics counter bank
module hsc_stat_counters_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import hsc_pkg::*;
	logic clk, srst, ce, one_sec_pin, chan_evt_v, rx_octet_v, rx_end_v, tx_octet_v, tx_end_v, tx_end_aborted;
	logic req_v, slow, req_ready, wr_v, wr_ready, command_done_ack, completion_irq;
	logic [CH_W-1:0] chan_evt_id, rx_octet_chan, tx_octet_chan, tx_end_chan;
	hsc_rx_end_t rx_end;
	hsc_limits_t max_len_limits;
	hsc_req_t req;
	hsc_wr_t wr;
	int error_cnt = 0;
	int total_checks = 0;
	localparam logic [21:0] RX3 = 22'h008018;

	hsc_stat_counters u_dut (.clk(clk), .srst(srst), .ce(ce), .one_sec_pin(one_sec_pin), .chan_evt_v(chan_evt_v),
		.chan_evt_id(chan_evt_id), .rx_octet_v(rx_octet_v), .rx_octet_chan(rx_octet_chan), .rx_end_v(rx_end_v),
		.rx_end(rx_end), .max_len_limits(max_len_limits), .tx_octet_v(tx_octet_v), .tx_octet_chan(tx_octet_chan),
		.tx_end_v(tx_end_v), .tx_end_chan(tx_end_chan), .tx_end_aborted(tx_end_aborted), .req_v(req_v), .req(req),
		.req_ready(req_ready), .wr_v(wr_v), .wr(wr), .wr_ready(wr_ready), .command_done_ack(command_done_ack),
		.completion_irq(completion_irq));
	hsc_host_mem u_host (.clk(clk), .slow(slow), .wr_v(wr_v), .wr(wr), .wr_ready(wr_ready));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk32
	task automatic chk_mem(input logic [23:0] e [8], input int n);
		for (int i = 0; i < n; i++) begin
			chk32(u_host.mem[16+i], {8'h00, e[i]}, "memory word");
		end
	endtask : chk_mem
	task automatic rx_oct(input logic [4:0] ch);
		@(negedge clk);
		rx_octet_chan = ch;
		rx_octet_v = 1'b1;
		@(negedge clk);
		rx_octet_v = 1'b0;
	endtask : rx_oct
	task automatic rx_msg(input logic [13:0] len, input logic [1:0] ls, input logic [4:0] fl);
		@(negedge clk);
		rx_end = {5'h03, len, ls, fl};
		rx_end_v = 1'b1;
		@(negedge clk);
		rx_end_v = 1'b0;
	endtask : rx_msg
	task automatic tx_evt(input logic oct, input logic ab);
		@(negedge clk);
		tx_octet_v = oct;
		tx_end_v = ~oct;
		tx_end_aborted = ab;
		@(negedge clk);
		tx_octet_v = 1'b0;
		tx_end_v = 1'b0;
	endtask : tx_evt
	// Pin high for one cycle; the latch acts two edges later
	task automatic pulse_sec();
		@(negedge clk);
		one_sec_pin = 1'b1;
		@(negedge clk);
		one_sec_pin = 1'b0;
	endtask : pulse_sec
	task automatic rd(input logic [21:0] base, input logic tx, input logic [13:0] len, input logic [4:0] op,
		input logic ie);
		int n;
		n = 0;
		@(negedge clk);
		while (req_ready !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk32(req_ready, 1'b1, "engine ready");
		req = {op, ie, len, 30'h00000010, base, tx};
		req_v = 1'b1;
		@(negedge clk);
		req_v = 1'b0;
		n = 0;
		while (command_done_ack !== 1'b1 && n < 70000) begin
			@(negedge clk);
			n++;
		end
		chk32(command_done_ack, 1'b1, "done pulse");
		chk32(completion_irq, ie && op == CONFIG_RD_DEFAULT, "completion irq");
	endtask : rd
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_rx();
		repeat (5) rx_oct(5'h03);
		rx_msg(14'h000a, 2'h3, 5'b00001);
		rx_msg(14'h0010, 2'h0, 5'b00001);
		rx_msg(14'h000a, 2'h3, 5'b10101);
		rx_msg(14'h0014, 2'h0, 5'b01001);
		rx_msg(14'h000a, 2'h3, 5'b01101);
		rx_msg(14'h000a, 2'h3, 5'b00101);
		rx_msg(14'h0002, 2'h3, 5'b00001);
		rx_msg(14'h000a, 2'h3, 5'b00011);
		rx_msg(14'h000a, 2'h3, 5'b00100);
		pulse_sec();
		repeat (4) @(negedge clk);
		slow = 1'b1;
		rd(RX3, 1'b0, 14'h0008, 5'h01, 1'b0);
		slow = 1'b0;
		chk_mem('{24'h5, 24'h2, 24'h1, 24'h1, 24'h1, 24'h1, 24'h2, 24'h0}, 8);
		chk32(u_host.last_addr, 32'h0000005c, "last address");
		$display("test rx counters finished");
	endtask : t_rx
	task automatic t_tx();
		repeat (3) tx_evt(1'b1, 1'b0);
		tx_evt(1'b0, 1'b0);
		tx_evt(1'b0, 1'b1);
		pulse_sec();
		repeat (4) @(negedge clk);
		rd(22'h008008, 1'b1, 14'h0004, 5'h01, 1'b0);
		chk_mem('{24'h2, 24'h3, 24'h1, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0}, 4);
		$display("test tx counters finished");
	endtask : t_tx
	task automatic t_period();
		pulse_sec();
		rx_oct(5'h03);
		repeat (3) @(negedge clk);
		rd(RX3, 1'b0, 14'h0008, 5'h01, 1'b1);
		chk_mem('{default: 24'h0}, 8);
		pulse_sec();
		repeat (6) @(negedge clk);
		rd(RX3, 1'b0, 14'h0008, 5'h01, 1'b0);
		chk_mem('{24'h1, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0}, 8);
		$display("test latch period finished");
	endtask : t_period
	task automatic t_clear();
		rx_oct(5'h03);
		rx_oct(5'h03);
		pulse_sec();
		repeat (4) @(negedge clk);
		chan_evt_id = 5'h03;
		chan_evt_v = 1'b1;
		@(negedge clk);
		chan_evt_v = 1'b0;
		rd(RX3, 1'b0, 14'h0008, 5'h01, 1'b0);
		chk_mem('{default: 24'h0}, 8);
		$display("test channel clear finished");
	endtask : t_clear
	task automatic t_len();
		int n0;
		n0 = u_host.n_wr;
		rd(RX3, 1'b0, 14'h0001, 5'h02, 1'b1);
		chk32(u_host.n_wr - n0, 32'h0, "foreign opcode writes");
		n0 = u_host.n_wr;
		rd(22'h008000, 1'b0, 14'h0000, 5'h01, 1'b1);
		chk32(u_host.n_wr - n0, 32'h4000, "zero length words");
		chk32(u_host.last_addr, 32'h0001003c, "zero length end address");
		$display("test request length finished");
	endtask : t_len
	// ----------------------------------------------------------------
	// Sequence and verdict
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude
	initial begin
		{srst, ce, one_sec_pin, chan_evt_v, rx_octet_v, rx_end_v, tx_octet_v, tx_end_v, tx_end_aborted} = 9'h101;
		{req_v, slow, chan_evt_id, rx_octet_chan, tx_octet_chan, tx_end_chan} = '0;
		tx_octet_chan = 5'h02;
		tx_end_chan = 5'h02;
		rx_end = '0;
		req = '0;
		ce = 1'b1;
		max_len_limits = {14'h0100, 14'h0080, 14'h0010};
		repeat (3) @(negedge clk);
		srst = 1'b0;
		t_rx();
		t_tx();
		t_period();
		t_clear();
		t_len();
		conclude();
	end
	// Cut a hang short well beyond the longest read of 16384 words
	initial begin
		#(100 * 95000);
		error_cnt++;
		conclude();
	end
endmodule : hsc_stat_counters_tb_top
